// File: core/srl_map.vh
/*
 * constants of the strap router and eeprom loader: strap level codes,
 * eeprom layout, bus timing and bus engine command codes.
 * assumes inclusion by bare name from the core/ design files.
 */
`ifndef SRL_MAP_VH
`define SRL_MAP_VH

// four-level strap codes from the analog level detector
`define SRL_LVL_LOW      2'h0
`define SRL_LVL_RES      2'h1
`define SRL_LVL_FLT      2'h2
`define SRL_LVL_HIGH     2'h3

// bus address bytes
`define SRL_EE_ADDR      8'hA0
`define SRL_OWN_BASE     8'hB0

// eeprom layout
`define SRL_EE_BYTES     1024
`define SRL_HDR_LEN      10'h003
`define SRL_HDR_BIT_CRC  7
`define SRL_HDR_BIT_MAP  6
`define SRL_HDR_BIT_BIG  5
`define SRL_MAP_BASE     10'h003
`define SRL_DATA_LEN     6'h25
`define SRL_CHK_FIXED    8'hA5

// timing: bus clock at most 1000 kHz, core clock 50000 kHz
`define SRL_CLK_KHZ      50000
`define SRL_BUS_MAX_KHZ  1000
`define SRL_QTR_CYC      ((`SRL_CLK_KHZ + 4 * `SRL_BUS_MAX_KHZ - 1) / (4 * `SRL_BUS_MAX_KHZ))
`define SRL_SETTLE_CYC   4

// bus engine commands
`define SRL_CMD_START    3'h0
`define SRL_CMD_STOP     3'h1
`define SRL_CMD_WRITE    3'h2
`define SRL_CMD_RD_ACK   3'h3
`define SRL_CMD_RD_NACK  3'h4

`endif

// File: core/srl_strap_cap.v
/*
 * strap capture: two-flop synchroniser, then a single capture after a
 * short settle time; the held value never changes until reset.
 * assumes straps are static board levels sampled on ref_clk.
 */
`timescale 1ns/1ns
`include "srl_map.vh"

module srl_strap_cap #(
	parameter WIDTH = 12
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             rst_b,
	input  wire             clk_en,
	// strap pins and held copy
	input  wire [WIDTH-1:0] pins,
	output reg  [WIDTH-1:0] held_r,
	output reg              valid_r
);

	localparam integer SETTLE = `SRL_SETTLE_CYC;

	reg [WIDTH-1:0] sync1_r;
	reg [WIDTH-1:0] sync2_r;
	reg [3:0]       cnt_r;

	always @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			sync1_r <= {WIDTH{1'b0}};
			sync2_r <= {WIDTH{1'b0}};
			held_r  <= {WIDTH{1'b0}};
			valid_r <= 1'b0;
			cnt_r   <= 4'h0;
		end
		else if (clk_en)
		begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			if (!valid_r)
			begin
				// wait until the synchroniser holds real pin data
				if (cnt_r == SETTLE[3:0])
				begin
					held_r  <= sync2_r;
					valid_r <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 4'h1;
			end
		end
	end

endmodule

// File: core/srl_bus_eng.v
/*
 * two-wire bus master engine: start, stop, byte write with ack check,
 * byte read with ack or nack. each bit is four quarter periods.
 * assumes open-drain pads with pull-ups and no clock stretching.
 */
`timescale 1ns/1ns
`include "srl_map.vh"

module srl_bus_eng (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       clk_en,
	// command side
	input  wire       cmd_valid,
	input  wire [2:0] cmd,
	input  wire [7:0] cmd_wdata,
	output wire       cmd_ready,
	output reg        done_r,
	output reg  [7:0] rdata_r,
	output reg        nack_r,
	// pads
	output reg        scl_oe_n_r,
	output reg        sda_oe_n_r,
	input  wire       sda_in
);

	localparam integer QTR_I = `SRL_QTR_CYC;
	localparam [7:0]   QTR   = QTR_I[7:0];

	reg [1:0] sda_s_r;
	reg       busy_r;
	reg [2:0] op_r;
	reg [8:0] sh_r;
	reg [3:0] bit_r;
	reg [1:0] q_r;
	reg [7:0] cnt_r;

	// released levels {scl, sda} for a quarter of an operation
	function [1:0] lines;
		input [2:0] op;
		input [1:0] q;
		input       b;
		begin
			if (op == `SRL_CMD_START)
				lines = (q == 2'h0) ? 2'b01 : (q == 2'h1) ? 2'b11 : (q == 2'h2) ? 2'b10 : 2'b00;
			else if (op == `SRL_CMD_STOP)
				lines = (q == 2'h0) ? 2'b00 : (q == 2'h1) ? 2'b10 : 2'b11;
			else
				lines = {(q == 2'h1) || (q == 2'h2), b};
		end
	endfunction

	wire       is_byte = (op_r != `SRL_CMD_START) && (op_r != `SRL_CMD_STOP);
	wire [1:0] q_inc   = q_r + 2'h1;
	wire [1:0] ln_acc  = lines(cmd, 2'h0, cmd_wdata[7] | (cmd != `SRL_CMD_WRITE));
	wire [1:0] ln_q    = lines(op_r, q_inc, sh_r[8]);
	wire [1:0] ln_bit  = lines(op_r, 2'h0, sh_r[7]);

	assign cmd_ready = !busy_r;

	always @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			sda_s_r    <= 2'b11;
			busy_r     <= 1'b0;
			op_r       <= `SRL_CMD_STOP;
			sh_r       <= 9'h1ff;
			bit_r      <= 4'h0;
			q_r        <= 2'h0;
			cnt_r      <= 8'h00;
			done_r     <= 1'b0;
			rdata_r    <= 8'h00;
			nack_r     <= 1'b0;
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end
		else if (clk_en)
		begin
			sda_s_r <= {sda_s_r[0], sda_in};
			done_r  <= 1'b0;
			if (!busy_r)
			begin
				if (cmd_valid)
				begin
					busy_r <= 1'b1;
					op_r   <= cmd;
					// reads release data bits; ninth bit is our ack or nack
					sh_r   <= (cmd == `SRL_CMD_WRITE) ? {cmd_wdata, 1'b1}
					        : {8'hff, cmd == `SRL_CMD_RD_NACK};
					bit_r  <= 4'h0;
					q_r    <= 2'h0;
					cnt_r  <= 8'h00;
					scl_oe_n_r <= ln_acc[1];
					sda_oe_n_r <= ln_acc[0];
				end
			end
			else if (cnt_r != QTR - 8'h01)
				cnt_r <= cnt_r + 8'h01;
			else
			begin
				cnt_r <= 8'h00;
				// sample in the middle of the high phase
				if (is_byte && q_r == 2'h1)
				begin
					if (bit_r != 4'h8)
						rdata_r <= {rdata_r[6:0], sda_s_r[1]};
					else
						nack_r <= sda_s_r[1];
				end
				if (q_r != 2'h3)
				begin
					q_r        <= q_inc;
					scl_oe_n_r <= ln_q[1];
					sda_oe_n_r <= ln_q[0];
				end
				else if (is_byte && bit_r != 4'h8)
				begin
					q_r        <= 2'h0;
					bit_r      <= bit_r + 4'h1;
					sh_r       <= {sh_r[7:0], 1'b1};
					scl_oe_n_r <= ln_bit[1];
					sda_oe_n_r <= ln_bit[0];
				end
				else
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

endmodule

// File: core/srl_top.v
/*
 * strap router and eeprom loader: decodes four-level straps into lane
 * routing and mute controls, and in master mode loads this device's
 * configuration bytes from a shared serial eeprom after its turn in the
 * read-enable / done chain arrives.
 * assumes strap levels arrive as 2-bit codes from a level detector, pads
 * are open drain with external pull-ups, and the eeprom answers at 0xA0.
 */
`timescale 1ns/1ns
`include "srl_map.vh"

module srl_top (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       clk_en,
	// strap pins
	input  wire [1:0] route_strap_a,
	input  wire [1:0] route_strap_b,
	input  wire [1:0] fanout_strap,
	input  wire [1:0] bus_mode_strap,
	input  wire [3:0] addr_strap,
	// load chain
	input  wire       chain_read_enable_n,
	output reg        chain_done_n_r,
	// two-wire bus pads
	output wire       scl_oe_n,
	output wire       sda_oe_n,
	input  wire       sda_in,
	// routing controls
	output reg        dest_out_from_a_r,
	output reg  [1:0] side_a_out_en_r,
	output reg  [1:0] side_b_out_en_r,
	output reg        strap_reserved_r,
	// status
	output reg  [7:0] own_addr_byte_r,
	output reg        master_mode_r,
	output reg        load_busy_r,
	output reg        load_error_r,
	// loaded configuration stream
	output reg        cfg_valid_r,
	output reg  [5:0] cfg_index_r,
	output reg  [7:0] cfg_data_r
);

	localparam [3:0] ST_IDLE   = 4'h0;
	localparam [3:0] ST_WAIT   = 4'h1;
	localparam [3:0] ST_START  = 4'h2;
	localparam [3:0] ST_DEVW   = 4'h3;
	localparam [3:0] ST_ADDR   = 4'h4;
	localparam [3:0] ST_RSTART = 4'h5;
	localparam [3:0] ST_DEVR   = 4'h6;
	localparam [3:0] ST_READ   = 4'h7;
	localparam [3:0] ST_STOP   = 4'h8;
	localparam [3:0] ST_NEXT   = 4'h9;
	localparam [3:0] ST_DONE   = 4'ha;

	localparam [1:0] JOB_HDR  = 2'h0;
	localparam [1:0] JOB_MAP  = 2'h1;
	localparam [1:0] JOB_DATA = 2'h2;

	localparam [9:0] HDR_LEN  = `SRL_HDR_LEN;

	// high-side input group: floating or high
	function grp_hi;
		input [1:0] lvl;
		begin
			grp_hi = (lvl == `SRL_LVL_FLT) || (lvl == `SRL_LVL_HIGH);
		end
	endfunction

	// output group: resistor or high
	function grp_rh;
		input [1:0] lvl;
		begin
			grp_rh = (lvl == `SRL_LVL_RES) || (lvl == `SRL_LVL_HIGH);
		end
	endfunction

	// eeprom device byte; large parts carry address bits 9:8 in it
	function [7:0] ee_dev;
		input [9:0] a;
		input       big;
		input       rd;
		begin
			ee_dev = `SRL_EE_ADDR | {5'h00, big ? a[9:8] : 2'b00, 1'b0} | {7'h00, rd};
		end
	endfunction

	wire [11:0] straps_held;
	wire        straps_ok;
	wire [1:0]  lv_a   = straps_held[11:10];
	wire [1:0]  lv_b   = straps_held[9:8];
	wire [1:0]  lv_fan = straps_held[7:6];
	wire [1:0]  lv_bus = straps_held[5:4];
	wire [3:0]  ad     = straps_held[3:0];

	srl_strap_cap #(
		.WIDTH (12)
	) u_straps (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.pins    ({route_strap_a, route_strap_b, fanout_strap, bus_mode_strap, addr_strap}),
		.held_r  (straps_held),
		.valid_r (straps_ok)
	);

	reg        eng_valid_r;
	reg [2:0]  eng_cmd_r;
	reg [7:0]  eng_wdata_r;
	wire       eng_ready;
	wire       eng_done;
	wire [7:0] eng_rdata;
	wire       eng_nack;

	srl_bus_eng u_eng (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.clk_en     (clk_en),
		.cmd_valid  (eng_valid_r),
		.cmd        (eng_cmd_r),
		.cmd_wdata  (eng_wdata_r),
		.cmd_ready  (eng_ready),
		.done_r     (eng_done),
		.rdata_r    (eng_rdata),
		.nack_r     (eng_nack),
		.scl_oe_n_r (scl_oe_n),
		.sda_oe_n_r (sda_oe_n),
		.sda_in     (sda_in)
	);

	reg [1:0] en_s_r;
	reg [3:0] st_r;
	reg [1:0] job_r;
	reg [9:0] addr_r;
	reg [5:0] left_r;
	reg [5:0] idx_r;
	reg       issued_r;
	reg       crc_en_r;
	reg       map_r;
	reg       big_r;
	reg [9:0] ptr_r;
	reg [7:0] sum_r;

	wire       in_a     = grp_hi(lv_a) && grp_hi(lv_b);
	wire       fan_res  = (lv_fan == `SRL_LVL_RES);
	wire       fan_both = (lv_fan == `SRL_LVL_HIGH);
	wire       out_a    = grp_rh(lv_a) && grp_rh(lv_b);
	wire [9:0] ad_w     = {6'h00, ad};
	wire [9:0] own_base = `SRL_HDR_LEN + ad_w * {4'h0, `SRL_DATA_LEN};
	wire [7:0] sum_nxt  = sum_r + eng_rdata;

	// command for the present bus step
	reg [2:0] cmd_nxt;
	reg [7:0] wdata_nxt;
	always @*
	begin
		cmd_nxt   = `SRL_CMD_START;
		wdata_nxt = 8'h00;
		case (st_r)
			ST_DEVW:
			begin
				cmd_nxt   = `SRL_CMD_WRITE;
				wdata_nxt = ee_dev(addr_r, big_r, 1'b0);
			end
			ST_ADDR:
			begin
				cmd_nxt   = `SRL_CMD_WRITE;
				wdata_nxt = addr_r[7:0];
			end
			ST_DEVR:
			begin
				cmd_nxt   = `SRL_CMD_WRITE;
				wdata_nxt = ee_dev(addr_r, big_r, 1'b1);
			end
			ST_READ:
				cmd_nxt = (left_r == 6'h01) ? `SRL_CMD_RD_NACK : `SRL_CMD_RD_ACK;
			ST_STOP:
				cmd_nxt = `SRL_CMD_STOP;
			default:
				cmd_nxt = `SRL_CMD_START;
		endcase
	end

	// routing follows the held straps only; nothing loaded touches it
	always @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			dest_out_from_a_r <= 1'b0;
			side_a_out_en_r   <= 2'b00;
			side_b_out_en_r   <= 2'b00;
			strap_reserved_r  <= 1'b0;
			own_addr_byte_r   <= `SRL_OWN_BASE;
			master_mode_r     <= 1'b0;
		end
		else if (clk_en && straps_ok)
		begin
			dest_out_from_a_r <= in_a;
			// mismatched route straps fall back to side b inputs
			strap_reserved_r  <= fan_res || (grp_hi(lv_a) != grp_hi(lv_b));
			// reserved fanout level mutes everything rather than guess
			side_a_out_en_r   <= {2{!fan_res && (fan_both || out_a)}};
			side_b_out_en_r   <= {2{!fan_res && (fan_both || !out_a)}};
			own_addr_byte_r   <= `SRL_OWN_BASE + {3'h0, ad, 1'b0};
			master_mode_r     <= (lv_bus == `SRL_LVL_FLT);
		end
	end

	always @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			en_s_r         <= 2'b11;
			st_r           <= ST_IDLE;
			job_r          <= JOB_HDR;
			addr_r         <= 10'h000;
			left_r         <= 6'h00;
			idx_r          <= 6'h00;
			issued_r       <= 1'b0;
			crc_en_r       <= 1'b0;
			map_r          <= 1'b0;
			big_r          <= 1'b0;
			ptr_r          <= 10'h000;
			sum_r          <= 8'h00;
			eng_valid_r    <= 1'b0;
			eng_cmd_r      <= `SRL_CMD_START;
			eng_wdata_r    <= 8'h00;
			chain_done_n_r <= 1'b1;
			load_busy_r    <= 1'b0;
			load_error_r   <= 1'b0;
			cfg_valid_r    <= 1'b0;
			cfg_index_r    <= 6'h00;
			cfg_data_r     <= 8'h00;
		end
		else if (clk_en)
		begin
			en_s_r      <= {en_s_r[0], chain_read_enable_n};
			eng_valid_r <= 1'b0;
			cfg_valid_r <= 1'b0;
			case (st_r)
				ST_IDLE:
					if (straps_ok)
						st_r <= (lv_bus == `SRL_LVL_FLT) ? ST_WAIT : ST_DONE;
				ST_WAIT:
					// the bus stays untouched until our turn in the chain
					if (!en_s_r[1])
					begin
						st_r        <= ST_START;
						load_busy_r <= 1'b1;
						job_r       <= JOB_HDR;
						addr_r      <= 10'h000;
						left_r      <= HDR_LEN[5:0];
						big_r       <= 1'b0;
					end
				ST_NEXT:
				begin
					idx_r <= 6'h00;
					sum_r <= 8'h00;
					if (load_error_r || job_r == JOB_DATA)
						st_r <= ST_DONE;
					else
					begin
						st_r <= ST_START;
						if (job_r == JOB_HDR && map_r)
						begin
							job_r  <= JOB_MAP;
							addr_r <= `SRL_MAP_BASE + {ad_w[8:0], 1'b0};
							left_r <= 6'h02;
						end
						else
						begin
							job_r  <= JOB_DATA;
							addr_r <= (job_r == JOB_MAP) ? ptr_r : own_base;
							left_r <= `SRL_DATA_LEN;
						end
					end
				end
				ST_DONE:
				begin
					load_busy_r    <= 1'b0;
					chain_done_n_r <= 1'b0;
				end
				default:
					if (!issued_r && eng_ready)
					begin
						issued_r    <= 1'b1;
						eng_valid_r <= 1'b1;
						eng_cmd_r   <= cmd_nxt;
						eng_wdata_r <= wdata_nxt;
					end
					else if (issued_r && eng_done)
					begin
						issued_r <= 1'b0;
						case (st_r)
							ST_START:
								st_r <= ST_DEVW;
							ST_RSTART:
								st_r <= ST_DEVR;
							ST_STOP:
								st_r <= ST_NEXT;
							ST_READ:
							begin
								left_r <= left_r - 6'h01;
								idx_r  <= idx_r + 6'h01;
								if (left_r == 6'h01)
									st_r <= ST_STOP;
								if (job_r == JOB_HDR && idx_r == 6'h00)
								begin
									crc_en_r <= eng_rdata[`SRL_HDR_BIT_CRC];
									map_r    <= eng_rdata[`SRL_HDR_BIT_MAP];
									big_r    <= eng_rdata[`SRL_HDR_BIT_BIG];
								end
								else if (job_r == JOB_MAP)
									ptr_r <= {ptr_r[1:0], eng_rdata};
								else if (job_r == JOB_DATA)
								begin
									sum_r       <= sum_nxt;
									cfg_valid_r <= 1'b1;
									cfg_index_r <= idx_r;
									cfg_data_r  <= eng_rdata;
									// last byte is the check byte
									if (left_r == 6'h01)
										load_error_r <= crc_en_r ? (sum_nxt != 8'h00)
										              : (eng_rdata != `SRL_CHK_FIXED);
								end
							end
							default:
								// address phases: a nack aborts the load
								if (eng_nack)
								begin
									load_error_r <= 1'b1;
									st_r         <= ST_STOP;
								end
								else
									st_r <= (st_r == ST_DEVW) ? ST_ADDR
									      : (st_r == ST_ADDR) ? ST_RSTART : ST_READ;
						endcase
					end
			endcase
		end
	end

endmodule

// File: sim/srl_top_sva.sv
/* port checker for srl_top: strap routing, own address byte, bus pacing.
   assumes straps stay put from reset release until capture. */
`timescale 1ns/1ns

module srl_top_sva (
	// clock and reset
	input wire       ref_clk,
	input wire       rst_b,
	// straps and chain
	input wire [1:0] route_strap_a,
	input wire [1:0] route_strap_b,
	input wire [1:0] fanout_strap,
	input wire [1:0] bus_mode_strap,
	input wire [3:0] addr_strap,
	input wire       chain_read_enable_n,
	// outputs
	input wire       scl_oe_n,
	input wire       sda_oe_n,
	input wire       dest_out_from_a_r,
	input wire [1:0] side_a_out_en_r,
	input wire [1:0] side_b_out_en_r,
	input wire [7:0] own_addr_byte_r,
	input wire       master_mode_r,
	input wire       load_busy_r,
	input wire       cfg_valid_r,
	input wire [5:0] cfg_index_r
);
	reg  [3:0]  age_r;
	reg  [11:0] cap_r;
	reg  [7:0]  per_r;
	reg         scl_d_r;
	// own copy of the pins at the edge whose values the design's capture holds
	wire        settled = (age_r == 4'hf);
	wire [1:0]  ra = cap_r[11:10];
	wire [1:0]  rb = cap_r[9:8];
	wire [1:0]  fo = cap_r[7:6];
	wire [3:0]  outs = {side_a_out_en_r, side_b_out_en_r};
	wire        scl_up = scl_oe_n && !scl_d_r;

	always @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			age_r   <= 4'h0;
			per_r   <= 8'hff;
			scl_d_r <= 1'b1;
		end
		else
		begin
			if (!settled)
				age_r <= age_r + 4'h1;
			if (age_r == 4'h2)
				cap_r <= {route_strap_a, route_strap_b, fanout_strap, bus_mode_strap, addr_strap};
			scl_d_r <= scl_oe_n;
			if (scl_up)
				per_r <= 8'h01;
			else if (per_r != 8'hff)
				per_r <= per_r + 8'h01;
		end
	end

	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	chk_input_side: assert property (settled |-> dest_out_from_a_r == (ra[1] && rb[1]))
		else $error("input side wrong");
	chk_fanout_both: assert property (settled && fo == 2'h3 |-> outs == 4'hf)
		else $error("fanout not on both sides");
	chk_out_side_b: assert property (settled && !fo[0] && !(ra[0] && rb[0]) |-> outs == 4'h3)
		else $error("side b drive wrong");
	chk_out_side_a: assert property (settled && !fo[0] && ra[0] && rb[0] |-> outs == 4'hc)
		else $error("side a drive wrong");
	chk_own_addr: assert property (settled |-> own_addr_byte_r == 8'hb0 + {3'h0, cap_r[3:0], 1'b0})
		else $error("own address wrong");
	chk_master_mode: assert property (settled |-> master_mode_r == (cap_r[5:4] == 2'h2))
		else $error("bus mode wrong");
	chk_no_early_bus: assert property ((chain_read_enable_n && !load_busy_r) [*4] |-> scl_oe_n && sda_oe_n)
		else $error("bus driven before its turn");
	chk_bus_rate: assert property (scl_up |-> per_r >= 8'h32)
		else $error("bus clock too fast");
	chk_cfg_pulse: assert property (cfg_valid_r |-> (cfg_index_r <= 6'h24) ##1 !cfg_valid_r)
		else $error("config byte pulse wrong");

	cover property (settled && fo == 2'h3);
	cover property ($fell(load_busy_r) && master_mode_r);
	cover property (cfg_valid_r && cfg_index_r == 6'h24);
endmodule

bind srl_top srl_top_sva chk (.*);

// File: sim/srl_ee_model.sv
/* serial eeprom model: 1024 bytes, answers device code 0xA0 with block bits.
   assumes pulled-up wires built by the bench; no clock stretching. */
`timescale 1ns/1ns

module srl_ee_model (
	// bus wires
	input wire scl,
	input wire sda,
	output reg sda_rel_r,
	// refuse every device byte
	input wire nack_all
);
	reg [7:0] mem [0:1023];
	reg [7:0] sh;
	reg [3:0] k;
	reg [1:0] ph;
	reg [1:0] blk;
	reg [9:0] ptr;
	reg       act = 1'b0;

	initial
		sda_rel_r = 1'b1;
	always @(negedge sda)
		if (scl)
		begin
			act = 1'b1;
			ph = 2'h0;
			k = 4'hf;
		end
	always @(posedge sda)
		if (scl)
			act = 1'b0;
	// read ack slot: step on, a nack ends the burst
	always @(posedge scl)
		if (act && k < 4'h8)
			sh = {sh[6:0], sda};
		else if (act && ph == 2'h2)
		begin
			ptr = ptr + 10'h001;
			if (sda)
				ph = 2'h3;
		end
	// sda only moves while scl is low, so no false start or stop
	always @(negedge scl)
	begin
		k = (k == 4'h8) ? 4'h0 : k + 4'h1;
		sda_rel_r = !(act && ph == 2'h2 && k < 4'h8) || mem[ptr][7 - k];
		if (act && k == 4'h8 && ph == 2'h1)
		begin
			ptr = {blk, sh};
			sda_rel_r = 1'b0;
		end
		if (act && k == 4'h8 && ph == 2'h0)
		begin
			blk = sh[2:1];
			ph = sh[0] ? 2'h2 : 2'h1;
			ptr = ptr - {9'h000, sh[0]};
			act = (sh[7:3] == 5'h14) && !nack_all;
			sda_rel_r = !act;
		end
	end
endmodule

// File: sim/srl_top_tb.sv
/* self-checking bench for srl_top: strap routing and eeprom loads.
   assumes the eeprom model and checker are compiled first. */
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done = checks_done + 1; if ((got) !== (exp)) begin \
	error_cnt = error_cnt + 1; $display("mismatch at %0t: got %h, expected %h", $time, got, exp); end end

module srl_top_tb;
	// clock, reset and straps
	reg        ref_clk             = 1'b0;
	reg        rst_b               = 1'b0;
	reg        clk_en              = 1'b1;
	reg  [1:0] route_strap_a       = 2'h0;
	reg  [1:0] route_strap_b       = 2'h0;
	reg  [1:0] fanout_strap        = 2'h0;
	reg  [1:0] bus_mode_strap      = 2'h0;
	reg  [3:0] addr_strap          = 4'h0;
	reg        chain_read_enable_n = 1'b1;
	reg        nack_all            = 1'b0;
	// design outputs
	wire       chain_done_n_r, scl_oe_n, sda_oe_n, sda_rel, dest_out_from_a_r, strap_reserved_r;
	wire       master_mode_r, load_busy_r, load_error_r, cfg_valid_r;
	wire [1:0] side_a_out_en_r, side_b_out_en_r;
	wire [7:0] own_addr_byte_r, cfg_data_r;
	wire [5:0] cfg_index_r;
	wire       sda_in = sda_oe_n & sda_rel;
	// bench state
	integer    error_cnt   = 0;
	integer    checks_done = 0;
	integer    i, j, n;
	reg [31:0] rnd;
	reg [7:0]  sum;
	reg [9:0]  er;
	reg [8:0]  frz;
	reg [7:0]  exp_d [0:36];

	always #10 ref_clk = ~ref_clk;

	srl_top dut (.*);
	srl_ee_model ee (.scl(scl_oe_n), .sda(sda_in), .sda_rel_r(sda_rel), .nack_all(nack_all));

	// {from_a, reserved, side a enables, side b enables}
	function [5:0] exp_route(input [1:0] a, input [1:0] b, input [1:0] f);
	begin
		exp_route[5] = a[1] & b[1];
		exp_route[4] = (f == 2'h1) || (a[1] != b[1]);
		exp_route[3:0] = (f == 2'h3) ? 4'hf : (f == 2'h1) ? 4'h0 : (a[0] & b[0]) ? 4'hc : 4'h3;
	end
	endfunction

	task stop_test;
	begin
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	task do_reset;
	begin
		rst_b = 1'b0;
		repeat (4) @(negedge ref_clk);
		rst_b = 1'b1;
	end
	endtask

	task route_test;
	begin
		for (i = 0; i < 64; i = i + 1)
		begin
			rnd = $urandom;
			// first sixteen sweep equal route straps against every fanout level
			route_strap_a = (i < 16) ? i[1:0] : rnd[1:0];
			route_strap_b = (i < 16) ? i[1:0] : rnd[3:2];
			fanout_strap = (i < 16) ? i[3:2] : rnd[5:4];
			addr_strap = rnd[9:6];
			bus_mode_strap = i[0] ? 2'h3 : 2'h0;
			do_reset;
			repeat (16) @(negedge ref_clk);
			er = {exp_route(route_strap_a, route_strap_b, fanout_strap), addr_strap};
			for (j = 0; j < 2; j = j + 1)
			begin
				`CHK({dest_out_from_a_r, strap_reserved_r, side_a_out_en_r, side_b_out_en_r}, er[9:4])
				`CHK(own_addr_byte_r, 8'hb0 + {3'h0, er[3:0], 1'b0})
				`CHK({master_mode_r, chain_done_n_r, scl_oe_n, sda_oe_n}, 4'h3)
				{route_strap_a, route_strap_b, fanout_strap, addr_strap} = ~{route_strap_a, route_strap_b, fanout_strap, addr_strap};
				repeat (8) @(negedge ref_clk);
			end
		end
		$display("routing test done");
	end
	endtask

	task fill(input [9:0] base, input crc);
	begin
		sum = 8'h00;
		for (j = 0; j < 36; j = j + 1)
		begin
			rnd = $urandom;
			exp_d[j] = rnd[7:0];
			sum = sum + rnd[7:0];
		end
		exp_d[36] = crc ? 8'h00 - sum : 8'ha5;
		for (j = 0; j < 37; j = j + 1)
			ee.mem[base + j] = exp_d[j];
	end
	endtask

	task load_run(input [3:0] adr, input exp_err, input [5:0] exp_n);
	begin
		rnd = $urandom;
		{route_strap_a, route_strap_b, fanout_strap} = rnd[5:0];
		bus_mode_strap = 2'h2;
		addr_strap = adr;
		chain_read_enable_n = 1'b1;
		do_reset;
		repeat (300) @(negedge ref_clk);
		`CHK({scl_oe_n, sda_oe_n, chain_done_n_r, master_mode_r}, 4'hf)
		chain_read_enable_n = 1'b0;
		n = 0;
		for (j = 0; j < 60000 && chain_done_n_r !== 1'b0; j = j + 1)
		begin
			@(negedge ref_clk);
			if (cfg_valid_r === 1'b1)
			begin
				`CHK({cfg_index_r, cfg_data_r}, {n[5:0], exp_d[n]})
				n = n + 1;
			end
			// freeze mid-load: both pads, busy and config index must hold while the enable is low
			if (j == 2000 && cfg_valid_r === 1'b0)
			begin
				frz = {scl_oe_n, sda_oe_n, load_busy_r, cfg_index_r};
				clk_en = 1'b0;
				repeat (20) @(negedge ref_clk);
				`CHK({scl_oe_n, sda_oe_n, load_busy_r, cfg_index_r}, frz)
				`CHK(load_busy_r, 1'b1)
				clk_en = 1'b1;
			end
		end
		if (j == 60000)
		begin
			error_cnt = error_cnt + 1;
			stop_test;
		end
		`CHK({load_error_r, load_busy_r, n[5:0]}, {exp_err, 1'b0, exp_n})
		`CHK({dest_out_from_a_r, strap_reserved_r, side_a_out_en_r, side_b_out_en_r}, exp_route(route_strap_a, route_strap_b, fanout_strap))
		$display("load test done");
	end
	endtask

	initial
	begin
		rnd = $urandom(7961);
		// known contents so unused header bytes never put unknowns on the wire
		for (j = 0; j < 1024; j = j + 1)
			ee.mem[j] = 8'h00;
		route_test;
		// small eeprom, no map, fixed check byte
		ee.mem[0] = 8'h00;
		fill(10'h072, 1'b0);
		load_run(4'h3, 1'b0, 6'h25);
		// large eeprom, map entry for address 5, summed check byte
		ee.mem[0] = 8'he0;
		ee.mem[13] = 8'h03;
		ee.mem[14] = 8'hc0;
		fill(10'h3c0, 1'b1);
		load_run(4'h5, 1'b0, 6'h25);
		// fixed check byte corrupted
		ee.mem[0] = 8'h00;
		fill(10'h003, 1'b0);
		exp_d[36] = 8'h5a;
		ee.mem[39] = 8'h5a;
		load_run(4'h0, 1'b1, 6'h25);
		nack_all = 1'b1;
		load_run(4'h1, 1'b1, 6'h00);
		stop_test;
	end
endmodule
